/* File: hdl/rrs_defs.svh */
// Constants for the return/rotate/sleep execution block
`ifndef RRS_DEFS_SVH
`define RRS_DEFS_SVH
`define RRS_DATA_W       8
`define RRS_ADDR_W       7
`define RRS_PC_W         13
`define RRS_WDT_W        8
`define RRS_PRE_W        16
`define RRS_RET_CYCLES   2
`define RRS_DEST_W       1'b0
`define RRS_DEST_F       1'b1
`define RRS_PD_SLEEP     1'b0
`define RRS_TO_SLEEP     1'b1
`define RRS_PD_RESET     1'b1
`define RRS_TO_RESET     1'b1
`define RRS_IRQ_RET      0
`define RRS_IRQ_ROT      1
`define RRS_IRQ_SLEEP    2
`define RRS_IRQ_WAKE     3
`define RRS_IRQ_N        4
`define RRS_REG_STATUS   8'h00
`define RRS_REG_MASK     8'h01
`define RRS_REG_CTRL     8'h02
`define RRS_REG_FLAGS    8'h03
`define RRS_WAKE_EN_RST  1'b1
`endif

/* File: hdl/rrs_pkg.sv */
// Types for the return/rotate/sleep execution block
package rrs_pkg;
  typedef enum logic [2:0] {
    RRS_OP_NONE   = 3'h0,
    RRS_OP_RETURN = 3'h1,
    RRS_OP_ROTL   = 3'h2,
    RRS_OP_ROTR   = 3'h3,
    RRS_OP_SLEEP  = 3'h4
  } rrs_op_t;
  typedef enum logic [3:0] {
    RRS_ST_RUN    = 4'h1,
    RRS_ST_RET2   = 4'h2,
    RRS_ST_ASLEEP = 4'h4,
    RRS_ST_WAKE   = 4'h8
  } rrs_state_t;
endpackage

/* File: hdl/rrs_rot_if.sv */
// Interface between the sequencer and the rotate unit
`timescale 1ns/1ps
interface rrs_rot_if;
  logic       dirRight;
  logic [7:0] operand;
  logic       carryIn;
  logic [7:0] result;
  logic       carryOut;
  modport core (output dirRight, output operand, output carryIn, input result, input carryOut);
  modport unit (input dirRight, input operand, input carryIn, output result, output carryOut);
endinterface

/* File: hdl/rrs_rotate.sv */
// Rotate-through-carry datapath
`timescale 1ns/1ps
module rrs_rotate (
  rrs_rot_if.unit rot
);
  // Nine-bit ring of carry and data
  always_comb begin
    if (rot.dirRight) begin
      rot.result   = {rot.carryIn, rot.operand[7:1]};
      rot.carryOut = rot.operand[0];
    end else begin
      rot.result   = {rot.operand[6:0], rot.carryIn};
      rot.carryOut = rot.operand[7];
    end
  end
endmodule

/* File: hdl/rrs_exec.sv */
// Execution of return, rotate and sleep instructions
`timescale 1ns/1ps
`include "rrs_defs.svh"
module rrs_exec #(
  parameter int DATA_W = `RRS_DATA_W,
  parameter int ADDR_W = `RRS_ADDR_W,
  parameter int PC_W   = `RRS_PC_W
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire rrs_pkg::rrs_op_t  opCode,
  input  wire logic              opValid,
  input  wire logic [ADDR_W-1:0] fileAddr,
  input  wire logic              destSel,
  input  wire logic [DATA_W-1:0] fileData,
  input  wire logic [PC_W-1:0]   stackHead,
  input  wire logic              wakeReq,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [7:0]             regRdData,
  output logic                   irq,
  output logic                   opReady,
  output logic [PC_W-1:0]        instructionPointer,
  output logic                   stackPop,
  output logic [DATA_W-1:0]      accumulator,
  output logic                   fileWr,
  output logic [ADDR_W-1:0]      fileWrAddr,
  output logic [DATA_W-1:0]      fileWrData,
  output logic                   carryFlag,
  output logic                   powerdownFlag,
  output logic                   expiryFlag,
  output logic                   watchdogClear,
  output logic                   oscHalt
);
  import rrs_pkg::*;

  // Sequencer state and its next value
  rrs_state_t            state_q;
  rrs_state_t            state_d;
  // Carrier to the rotate unit
  rrs_rot_if             rotBus ();
  // Wake pin synchroniser
  logic                  wakeMeta_q;
  logic                  wakeSync_q;
  // Software-visible registers
  logic [`RRS_IRQ_N-1:0] status_q;
  logic [`RRS_IRQ_N-1:0] statusClr;
  logic [`RRS_IRQ_N-1:0] mask_q;
  logic                  wakeEnable_q;
  logic                  pending;
  logic [7:0]            rdMux;
  logic [7:0]            flagsView;
  // Instruction decode
  logic                  take;
  logic                  isRot;
  logic                  isAsleep;
  logic                  takeRet;
  logic                  takeRot;
  logic                  takeSleep;
  logic                  wakeGo;
  logic [`RRS_IRQ_N-1:0] evt;

  // Wake request is asynchronous; first stage may go metastable
  always_ff @(posedge mclk) begin
    if (rst) begin
      wakeMeta_q <= 1'b0;
    end else begin
      wakeMeta_q <= wakeReq;
    end
  end

  // Second stage; only this one feeds logic
  always_ff @(posedge mclk) begin
    if (rst) begin
      wakeSync_q <= 1'b0;
    end else begin
      wakeSync_q <= wakeMeta_q;
    end
  end

  // Offers count only while running; refused in the stall and in sleep
  assign take      = opValid && (state_q == RRS_ST_RUN);
  assign isRot     = (opCode == RRS_OP_ROTL) || (opCode == RRS_OP_ROTR);
  assign isAsleep  = (state_q == RRS_ST_ASLEEP);
  assign takeRet   = take && (opCode == RRS_OP_RETURN);
  assign takeRot   = take && isRot;
  assign takeSleep = take && (opCode == RRS_OP_SLEEP);
  // Software may hold the core asleep by clearing the wake enable
  assign wakeGo    = isAsleep && wakeSync_q && wakeEnable_q;

  // Rotate datapath; operand is the live file register value
  assign rotBus.dirRight = (opCode == RRS_OP_ROTR);
  assign rotBus.operand  = fileData;
  assign rotBus.carryIn  = carryFlag;

  rrs_rotate u_rot (
    .rot (rotBus.unit)
  );

  // Next state: return stalls one extra cycle, sleep parks until wake
  always_comb begin
    state_d = state_q;
    case (state_q)
      RRS_ST_RUN: begin
        if (takeRet) begin
          state_d = RRS_ST_RET2;
        end else if (takeSleep) begin
          state_d = RRS_ST_ASLEEP;
        end
      end
      RRS_ST_RET2: begin
        state_d = RRS_ST_RUN;
      end
      RRS_ST_ASLEEP: begin
        if (wakeGo) begin
          state_d = RRS_ST_WAKE;
        end
      end
      RRS_ST_WAKE: begin
        state_d = RRS_ST_RUN;
      end
      default: begin
        // Illegal code recovers to running rather than locking up
        state_d = RRS_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= RRS_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Ready is the registered view of the next state being RUN
  always_ff @(posedge mclk) begin
    if (rst) begin
      opReady <= 1'b1;
    end else begin
      opReady <= (state_d == RRS_ST_RUN);
    end
  end

  // Oscillator halts for the whole sleep state
  always_ff @(posedge mclk) begin
    if (rst) begin
      oscHalt <= 1'b0;
    end else begin
      oscHalt <= (state_d == RRS_ST_ASLEEP);
    end
  end

  // Pointer takes the stack head in the first return cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      instructionPointer <= '0;
    end else if (takeRet) begin
      instructionPointer <= stackHead;
    end
  end

  // One pop pulse per return; the stack itself lives outside
  always_ff @(posedge mclk) begin
    if (rst) begin
      stackPop <= 1'b0;
    end else begin
      stackPop <= takeRet;
    end
  end

  // Carry is the only flag a rotate touches
  always_ff @(posedge mclk) begin
    if (rst) begin
      carryFlag <= 1'b0;
    end else if (takeRot) begin
      carryFlag <= rotBus.carryOut;
    end
  end

  // Accumulator destination
  always_ff @(posedge mclk) begin
    if (rst) begin
      accumulator <= '0;
    end else if (takeRot && destSel == `RRS_DEST_W) begin
      accumulator <= rotBus.result;
    end
  end

  // File destination strobe, one cycle per rotate
  always_ff @(posedge mclk) begin
    if (rst) begin
      fileWr <= 1'b0;
    end else begin
      fileWr <= takeRot && destSel == `RRS_DEST_F;
    end
  end

  // File write address and data; held between writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      fileWrAddr <= '0;
      fileWrData <= '0;
    end else if (takeRot && destSel == `RRS_DEST_F) begin
      fileWrAddr <= fileAddr;
      fileWrData <= rotBus.result;
    end
  end

  // Sleep clears the power-down flag; only reset sets it again
  always_ff @(posedge mclk) begin
    if (rst) begin
      powerdownFlag <= `RRS_PD_RESET;
    end else if (takeSleep) begin
      powerdownFlag <= `RRS_PD_SLEEP;
    end
  end

  // Sleep sets the expiry flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      expiryFlag <= `RRS_TO_RESET;
    end else if (takeSleep) begin
      expiryFlag <= `RRS_TO_SLEEP;
    end
  end

  // One pulse clears both watchdog counter and prescaler
  always_ff @(posedge mclk) begin
    if (rst) begin
      watchdogClear <= 1'b0;
    end else begin
      watchdogClear <= takeSleep;
    end
  end

  // Event sources for the sticky status
  always_comb begin
    evt = '0;
    evt[`RRS_IRQ_RET]   = takeRet;
    evt[`RRS_IRQ_ROT]   = takeRot;
    evt[`RRS_IRQ_SLEEP] = takeSleep;
    evt[`RRS_IRQ_WAKE]  = state_q == RRS_ST_WAKE;
  end

  // Write-one-to-clear pattern for the status register
  always_comb begin
    statusClr = '0;
    if (regWr && regAddr == `RRS_REG_STATUS) begin
      statusClr = regWrData[`RRS_IRQ_N-1:0];
    end
  end

  // Sticky status; a new event beats a same-cycle clear so none is lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~statusClr) | evt;
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= '0;
    end else if (regWr && regAddr == `RRS_REG_MASK) begin
      mask_q <= regWrData[`RRS_IRQ_N-1:0];
    end
  end

  // Wake enable; with it clear a wake request is ignored, not latched
  always_ff @(posedge mclk) begin
    if (rst) begin
      wakeEnable_q <= `RRS_WAKE_EN_RST;
    end else if (regWr && regAddr == `RRS_REG_CTRL) begin
      wakeEnable_q <= regWrData[0];
    end
  end

  // Any unmasked sticky bit
  assign pending = |(status_q & mask_q);

  // Interrupt level, registered; lags the status by one cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= pending;
    end
  end

  // Read-only image of the core flags
  assign flagsView = {3'h0, oscHalt, isAsleep, carryFlag, expiryFlag, powerdownFlag};

  // Read selection; unmapped addresses read zero
  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      `RRS_REG_STATUS: begin
        rdMux = {4'h0, status_q};
      end
      `RRS_REG_MASK: begin
        rdMux = {4'h0, mask_q};
      end
      `RRS_REG_CTRL: begin
        rdMux = {7'h00, wakeEnable_q};
      end
      `RRS_REG_FLAGS: begin
        rdMux = flagsView;
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule

/* File: verif/rrs_exec_checker.sv */
// Port assertions for the return/rotate/sleep block
`timescale 1ns/1ps
module rrs_exec_checker (
  input logic             mclk,
  input logic             rst,
  input rrs_pkg::rrs_op_t opCode,
  input logic             opValid,
  input logic             destSel,
  input logic [7:0]       fileData,
  input logic [12:0]      stackHead,
  input logic             opReady,
  input logic [12:0]      instructionPointer,
  input logic             stackPop,
  input logic [7:0]       accumulator,
  input logic             fileWr,
  input logic [7:0]       fileWrData,
  input logic             carryFlag,
  input logic             powerdownFlag,
  input logic             expiryFlag,
  input logic             watchdogClear,
  input logic             oscHalt
);
  import rrs_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Only an offer seen while ready counts as taken
  wire take = opValid && opReady;
  sequence ret_tail;
    !opReady ##1 opReady;
  endsequence
  sequence clear_pulse;
    watchdogClear ##1 !watchdogClear;
  endsequence
  chk_ret_load: assert property (
    take && opCode == RRS_OP_RETURN |=> stackPop && instructionPointer == $past(stackHead))
    else $error("Return did not load the pointer");
  chk_ret_two: assert property (
    take && opCode == RRS_OP_RETURN |=> ret_tail) else $error("Return length wrong");
  chk_rotl_file: assert property (
    take && opCode == RRS_OP_ROTL && destSel |=> fileWr && carryFlag == $past(fileData[7])
    && fileWrData == {$past(fileData[6:0]), $past(carryFlag)}) else $error("Left rotate wrong");
  chk_rotr_acc: assert property (
    take && opCode == RRS_OP_ROTR && !destSel |=> !fileWr && carryFlag == $past(fileData[0])
    && accumulator == {$past(carryFlag), $past(fileData[7:1])}) else $error("Right rotate wrong");
  chk_sleep_flags: assert property (
    take && opCode == RRS_OP_SLEEP |=> !powerdownFlag && expiryFlag) else $error("Sleep flags wrong");
  chk_wdt_clear: assert property (
    take && opCode == RRS_OP_SLEEP |=> clear_pulse) else $error("Watchdog clear missing");
  chk_osc_halt: assert property (
    take && opCode == RRS_OP_SLEEP |=> (oscHalt && !opReady) [*2]) else $error("Sleep did not halt");
  chk_rot_single: assert property (
    take && (opCode == RRS_OP_ROTL || opCode == RRS_OP_ROTR) |=> opReady && $stable(powerdownFlag)
    && $stable(expiryFlag) && $stable(instructionPointer)) else $error("Rotate side effect");
  chk_pop_single: assert property (
    stackPop |=> !stackPop) else $error("Pop pulse too long");
endmodule
bind rrs_exec rrs_exec_checker chk_i (.mclk, .rst, .opCode, .opValid, .destSel, .fileData, .stackHead,
  .opReady, .instructionPointer, .stackPop, .accumulator, .fileWr, .fileWrData, .carryFlag,
  .powerdownFlag, .expiryFlag, .watchdogClear, .oscHalt);

/* File: verif/rrs_exec_bench.sv */
// Self-checking bench for the return/rotate/sleep block
`timescale 1ns/1ps
module rrs_exec_bench;
  import rrs_pkg::*;
  rrs_op_t     opCode = RRS_OP_NONE;
  logic        mclk = 1'b0, rst = 1'b1, opValid = 1'b0, destSel = 1'b0, wakeReq = 1'b0;
  logic        regWr = 1'b0, regRd = 1'b0, cExp = 1'b0;
  logic [6:0]  fileAddr = 7'h00, fileWrAddr;
  logic [7:0]  fileData = 8'h00, regAddr = 8'h00, regWrData = 8'h00, regRdData, accumulator, fileWrData;
  logic [12:0] stackHead = 13'h0000, instructionPointer;
  logic        irq, opReady, stackPop, fileWr, carryFlag, powerdownFlag, expiryFlag, watchdogClear, oscHalt;
  logic [8:0]  r;
  int          num_errors = 0, samples_checked = 0;
  rrs_exec dut (.mclk, .rst, .opCode, .opValid, .fileAddr, .destSel, .fileData, .stackHead, .wakeReq,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .irq, .opReady, .instructionPointer, .stackPop,
    .accumulator, .fileWr, .fileWrAddr, .fileWrData, .carryFlag, .powerdownFlag, .expiryFlag,
    .watchdogClear, .oscHalt);
  // 100 ns clock
  initial forever #50 mclk = ~mclk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Expected {carry, result} of a rotate through carry
  function automatic logic [8:0] rot(input logic right, input logic [7:0] d, input logic c);
    return right ? {d[0], c, d[7:1]} : {d[7], d[6:0], c};
  endfunction
  // One offered instruction; returns just after the edge that takes it
  task automatic op(input rrs_op_t o, input logic d);
    @(posedge mclk);
    opCode    <= o;
    opValid   <= 1'b1;
    destSel   <= d;
    fileData  <= 8'($urandom);
    fileAddr  <= 7'($urandom);
    stackHead <= 13'($urandom);
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
  endtask
  // One register cycle; read data is valid just after it
  task automatic reg_io(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr     <= wr;
    regRd     <= ~wr;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hE88241B9));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk({opReady, powerdownFlag, expiryFlag, carryFlag}, 16'hE);
    reg_io(1'b1, 8'h01, 8'h0F);
    for (int i = 0; i < 24; i++) begin
      op(rrs_op_t'(3'h2 + 3'(i % 2)), 1'($urandom));
      r = rot(i[0], fileData, cExp);
      chk({fileWr, carryFlag, opReady}, {destSel, r[8], 1'b1});
      chk(destSel ? fileWrData : accumulator, r[7:0]);
      if (destSel) chk(fileWrAddr, fileAddr);
      cExp = r[8];
    end
    reg_io(1'b0, 8'h00, 8'h00);
    chk({irq, regRdData}, 16'h102);
    reg_io(1'b1, 8'h01, 8'h00);
    reg_io(1'b0, 8'h7F, 8'h00);
    chk({irq, regRdData}, 16'h000);
    reg_io(1'b1, 8'h00, 8'h02);
    reg_io(1'b1, 8'h01, 8'h0F);
    reg_io(1'b0, 8'h00, 8'h00);
    chk({irq, regRdData}, 16'h000);
    op(RRS_OP_RETURN, 1'b0);
    chk({stackPop, opReady, instructionPointer}, {2'b10, stackHead});
    @(posedge mclk);
    #1;
    chk({stackPop, opReady}, 16'h1);
    op(RRS_OP_SLEEP, 1'b0);
    chk({powerdownFlag, expiryFlag, watchdogClear, oscHalt, opReady}, 16'hE);
    op(RRS_OP_ROTL, 1'b1);
    chk({fileWr, carryFlag, oscHalt, opReady}, {1'b0, cExp, 2'b10});
    reg_io(1'b0, 8'h03, 8'h00);
    chk(regRdData, {11'h003, cExp, 2'b10});
    reg_io(1'b1, 8'h02, 8'h00);
    @(posedge mclk);
    wakeReq <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk({opReady, oscHalt}, 16'h1);
    reg_io(1'b1, 8'h02, 8'h01);
    @(posedge mclk);
    wakeReq <= 1'b1;
    for (int n = 0; n < 10 && opReady !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk({opReady, oscHalt, powerdownFlag}, 16'h4);
    tally_and_finish();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #(100 * 5000);
    num_errors++;
    tally_and_finish();
  end
endmodule
